// *** core/swr_pkg.sv ***
package swr_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ         = 125000;
	localparam int ERR_HOLD_MS     = 2000;
	localparam int ERR_HOLD_CYCLES = ERR_HOLD_MS * CLK_KHZ;
	localparam int ERR_CNT_W       = 28;

	// ----------------------------------------------------------------
	// Register map (byte addresses on APB)
	// ----------------------------------------------------------------
	localparam int         APB_AW     = 8;
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SWIPES_OFS = 8'h08;
	localparam logic [7:0] IDENT_OFS  = 8'h0C;
	localparam logic [7:0] CFG_BASE   = 8'h40;
	localparam logic [7:0] CFG_END    = 8'h68;
	localparam int         CFG_COUNT  = 10;
	localparam int         CTRL_FULL_BIT = 0;
	localparam logic       CTRL_FULL_RESET = 1'b0;
	localparam int ST_RED_BIT = 0;
	localparam int ST_GREEN_BIT = 1;
	localparam int ST_SUSP_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	localparam int ST_LOADED_BIT = 4;
	localparam int ST_NV_BUSY_BIT = 5;

	// Feature report identity returned by the ident register
	localparam logic [15:0] HID_VENDOR_PAGE = 16'hFF00;
	localparam logic [7:0]  HID_CMD_USAGE   = 8'h20;
	localparam logic [7:0]  RPT_BYTES       = 8'h18;
	localparam int          RPT_DATA_BYTES  = 22;
	localparam logic [31:0] IDENT_WORD =
		{HID_VENDOR_PAGE, HID_CMD_USAGE, RPT_BYTES};

	// ----------------------------------------------------------------
	// Formatting characters and their store indices
	// ----------------------------------------------------------------
	localparam int CFG_TERM = 0;
	localparam int CFG_PRE_CARD = 1;
	localparam int CFG_POST_CARD = 2;
	localparam int CFG_PRE_TRACK = 3;
	localparam int CFG_POST_TRACK = 4;
	localparam int CFG_T2_WIDE = 5;
	localparam int CFG_T3_LICENCE = 6;
	localparam int CFG_T3_BANK = 7;
	localparam int CFG_T3_MOTOR = 8;
	localparam int CFG_T3_WIDE = 9;
	localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{8'h0D, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h40, 8'h21, 8'h2B, 8'h23, 8'h26};
	localparam logic [7:0] CH_T1_SS = 8'h25;
	localparam logic [7:0] CH_T2_SS = 8'h3B;
	localparam logic [7:0] CH_ES    = 8'h3F;
	localparam logic [7:0] CH_CR    = 8'h0D;
	localparam logic [7:0] CH_ERR   = 8'h45;
	localparam logic [1:0] ENC_ISO = 2'h0;
	localparam logic [1:0] ENC_LICENCE = 2'h1;
	localparam logic [1:0] ENC_MOTOR = 2'h2;
	localparam logic [1:0] ENC_WIDE = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       present;
		logic       error;
		logic [1:0] enc;
		logic [7:0] lrc;
	} swr_trk_sum_type;

	typedef struct packed {
		logic       ctrl;
		logic [6:0] code;
	} swr_key_type;

	typedef enum logic [3:0] {F_IDLE, F_PRECARD, F_PRETRK, F_SS, F_DATA,
		F_ES, F_LRC, F_POSTTRK, F_TERM, F_NEXT, F_END} swr_fmt_state_type;
	typedef enum logic [1:0] {L_ATTACH, L_GREEN, L_DARK, L_ERROR}
		swr_led_state_type;
	typedef enum logic [1:0] {LD_START, LD_READ, LD_IDLE, LD_WRITE}
		swr_ld_state_type;

	// Control codes become Ctrl+(code|0x40), DEL becomes Ctrl+?, lower case letters go up
	function automatic swr_key_type to_key(input logic [7:0] c);
		swr_key_type k;
		k.ctrl = (c < 8'h20) || (c == 8'h7F);
		if (c < 8'h20) k.code = c[6:0] | 7'h40;
		else if (c == 8'h7F) k.code = 7'h3F;
		else if (c >= 8'h61 && c <= 8'h7A) k.code = c[6:0] - 7'h20;
		else k.code = c[6:0];
		return k;
	endfunction

endpackage

// *** core/swr_indicator.sv ***
`timescale 1ns/10ps
module swr_indicator #(
	parameter int ERR_CYCLES = swr_pkg::ERR_HOLD_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic usb_configured,
	input  wire logic usb_suspend,
	input  wire logic swipe_active,
	input  wire logic swipe_done,
	input  wire logic swipe_error,
	output logic      led_red,
	output logic      led_green
);
	swr_pkg::swr_led_state_type st_reg, st_next;
	logic [swr_pkg::ERR_CNT_W-1:0] cnt_reg, cnt_next;

	// ----------------------------------------------------------------
	// Indicator sequencing; suspend freezes state and error timer and darkens both lamps, so resume
	// comes back to exactly the same colour and remaining time
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		if (usb_suspend) begin
			st_next = st_reg;
		end else if (!usb_configured) begin
			st_next = swr_pkg::L_ATTACH;
		end else if (st_reg != swr_pkg::L_ATTACH && swipe_done) begin
			if (swipe_error) begin
				st_next = swr_pkg::L_ERROR;
				cnt_next = swr_pkg::ERR_CNT_W'(ERR_CYCLES - 1);
			end else begin
				st_next = swr_pkg::L_GREEN;
			end
		end else begin
			case (st_reg)
				swr_pkg::L_ATTACH: st_next = swr_pkg::L_GREEN;
				swr_pkg::L_GREEN: begin
					if (swipe_active) st_next = swr_pkg::L_DARK;
				end
				swr_pkg::L_DARK: st_next = swr_pkg::L_DARK;
				default: begin
					if (swipe_active) st_next = swr_pkg::L_DARK;
					else if (cnt_reg == '0) st_next = swr_pkg::L_GREEN;
					else cnt_next = cnt_reg - swr_pkg::ERR_CNT_W'(1);
				end
			endcase
		end
	end

	// State, timer and lamp drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= swr_pkg::L_ATTACH;
			cnt_reg <= '0;
			led_red <= 1'b0;
			led_green <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			led_red <= !usb_suspend && (st_reg == swr_pkg::L_ATTACH
				|| st_reg == swr_pkg::L_ERROR);
			led_green <= !usb_suspend && st_reg == swr_pkg::L_GREEN;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_suspend_lamp_off: assert property (
		usb_suspend |=> !led_red && !led_green)
		else $error("lamp lit during suspend");
	a_error_shows_red: assert property (
		!usb_suspend && usb_configured && st_reg != swr_pkg::L_ATTACH
		&& swipe_done && swipe_error ##1 !usb_suspend |=> led_red)
		else $error("decode error did not show red");
	a_swipe_goes_dark: assert property (
		st_reg == swr_pkg::L_DARK && !usb_suspend |=> !led_red
		&& !led_green) else $error("lamp lit during swipe");
	a_attach_shows_red: assert property (
		!usb_configured && !usb_suspend ##1 !usb_suspend |=> led_red)
		else $error("no red before enumeration");
endmodule

// *** core/swr_cfg_loader.sv ***
`timescale 1ns/10ps
module swr_cfg_loader #(
	parameter int ENTRIES = swr_pkg::CFG_COUNT
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       wr_req,
	input  wire logic [3:0] wr_idx,
	input  wire logic [7:0] wr_data,
	input  wire logic       nv_ack,
	input  wire logic [7:0] nv_rdata,
	output logic            nv_rd,
	output logic            nv_wr,
	output logic      [3:0] nv_addr,
	output logic      [7:0] nv_wdata,
	output logic            ld_we,
	output logic      [3:0] ld_idx,
	output logic      [7:0] ld_data,
	output logic            busy,
	output logic            done
);
	swr_pkg::swr_ld_state_type st_reg;
	wire last_entry = nv_addr == 4'(ENTRIES - 1);

	// ----------------------------------------------------------------
	// One pass over the store after reset, then write-through only
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= swr_pkg::LD_START;
			{nv_rd, nv_wr, ld_we, busy, done} <= 5'h02;
			nv_addr <= 4'h0;
			nv_wdata <= 8'h00;
			ld_idx <= 4'h0;
			ld_data <= 8'h00;
		end else begin
			ld_we <= 1'b0;
			case (st_reg)
				swr_pkg::LD_START: begin
					nv_rd <= 1'b1;
					st_reg <= swr_pkg::LD_READ;
				end
				swr_pkg::LD_READ: if (nv_ack) begin
					ld_we <= 1'b1;
					ld_idx <= nv_addr;
					ld_data <= nv_rdata;
					nv_addr <= nv_addr + 4'h1;
					if (last_entry) begin
						nv_rd <= 1'b0;
						busy <= 1'b0;
						done <= 1'b1;
						st_reg <= swr_pkg::LD_IDLE;
					end
				end
				swr_pkg::LD_IDLE: if (wr_req) begin
					nv_wr <= 1'b1;
					nv_addr <= wr_idx;
					nv_wdata <= wr_data;
					busy <= 1'b1;
					st_reg <= swr_pkg::LD_WRITE;
				end
				default: if (nv_ack) begin
					nv_wr <= 1'b0;
					busy <= 1'b0;
					st_reg <= swr_pkg::LD_IDLE;
				end
			endcase
		end
	end
endmodule

// *** core/swr_reader_top.sv ***
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module swr_reader_top #(
	parameter int ERR_CYCLES = swr_pkg::ERR_HOLD_CYCLES
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [swr_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     usb_configured,
	input  wire logic                     usb_suspend,
	input  wire logic                     swipe_active,
	input  wire logic                     swipe_done,
	input  wire swr_pkg::swr_trk_sum_type [2:0] trk_sum,
	input  wire logic                     trk_char_valid,
	input  wire logic [7:0]               trk_char,
	input  wire logic                     trk_char_last,
	output logic                          trk_char_ready,
	output logic                          key_valid,
	input  wire logic                     key_ready,
	output swr_pkg::swr_key_type          key,
	output logic                          led_red,
	output logic                          led_green,
	output logic                          nv_rd,
	output logic                          nv_wr,
	output logic      [3:0]               nv_addr,
	output logic      [7:0]               nv_wdata,
	input  wire logic                     nv_ack,
	input  wire logic [7:0]               nv_rdata
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic                        full_reg;
	logic [15:0]                 swipe_cnt_reg;
	logic [7:0]                  cfg_reg [swr_pkg::CFG_COUNT];
	swr_pkg::swr_fmt_state_type  st_reg, st_next, nxt;
	logic [1:0]                  trk_reg;
	swr_pkg::swr_trk_sum_type [2:0] sum_reg;
	logic                        wr_pend_reg;
	logic                        want, gate, step;
	logic [7:0]                  ch;
	logic                        ld_we, ld_busy, ld_done;
	logic [3:0]                  ld_idx;
	logic [7:0]                  ld_data;

	// ----------------------------------------------------------------
	// APB address decode and read mux
	// ----------------------------------------------------------------
	wire       apb_acc    = psel && penable;
	wire       apb_new    = apb_acc && !pready;
	wire       commit     = apb_acc && pready;
	wire       aligned    = paddr[1:0] == 2'h0;
	wire       hit_ctrl   = paddr == swr_pkg::CTRL_OFS;
	wire       hit_status = paddr == swr_pkg::STATUS_OFS;
	wire       hit_swipes = paddr == swr_pkg::SWIPES_OFS;
	wire       hit_ident  = paddr == swr_pkg::IDENT_OFS;
	wire       hit_cfg    = aligned && paddr >= swr_pkg::CFG_BASE
		&& paddr < swr_pkg::CFG_END;
	wire       hit_any    = hit_ctrl || hit_status || hit_swipes
		|| hit_ident || hit_cfg;
	wire [7:0] cfg_off    = paddr - swr_pkg::CFG_BASE;
	wire [3:0] cfg_idx    = cfg_off[5:2];
	wire       cfg_write  = pwrite && hit_cfg;

	// Store writes hold the access phase until the store has taken
	// them, so the answer means the setting is already durable
	wire wr_req  = apb_new && cfg_write && !wr_pend_reg && ld_done
		&& !ld_busy;
	wire respond = apb_new && ld_done && !ld_busy
		&& (!cfg_write || wr_pend_reg);

	wire [31:0] status_word =
		(32'(led_red) << swr_pkg::ST_RED_BIT)
		| (32'(led_green) << swr_pkg::ST_GREEN_BIT)
		| (32'(usb_suspend) << swr_pkg::ST_SUSP_BIT)
		| (32'(st_reg != swr_pkg::F_IDLE) << swr_pkg::ST_BUSY_BIT)
		| (32'(ld_done) << swr_pkg::ST_LOADED_BIT)
		| (32'(ld_busy) << swr_pkg::ST_NV_BUSY_BIT);
	wire [31:0] rd_word =
		hit_ctrl   ? {31'h0, full_reg} :
		hit_status ? status_word :
		hit_swipes ? {16'h0, swipe_cnt_reg} :
		hit_ident  ? swr_pkg::IDENT_WORD :
		hit_cfg    ? {24'h0, cfg_reg[cfg_idx]} : 32'h0;

	// APB answer: one cycle of pready, reads carry their data with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			wr_pend_reg <= 1'b0;
		end else begin
			pready <= respond;
			pslverr <= respond && !hit_any;
			prdata <= (respond && !pwrite) ? rd_word : 32'h0;
			if (wr_req) wr_pend_reg <= 1'b1;
			else if (commit) wr_pend_reg <= 1'b0;
		end
	end

	// Control bit and local copy of the formatting characters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_reg <= swr_pkg::CTRL_FULL_RESET;
			for (int i = 0; i < swr_pkg::CFG_COUNT; i++)
				cfg_reg[i] <= swr_pkg::CFG_RESET[i];
		end else begin
			if (commit && pwrite && hit_ctrl)
				full_reg <= pwdata[swr_pkg::CTRL_FULL_BIT];
			if (commit && cfg_write)
				cfg_reg[cfg_idx] <= pwdata[7:0];
			else if (ld_we)
				cfg_reg[ld_idx] <= ld_data;
		end
	end

	// ----------------------------------------------------------------
	// Configuration store and indicator
	// ----------------------------------------------------------------
	swr_cfg_loader #(
		.ENTRIES (swr_pkg::CFG_COUNT)
	) u_loader (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_req   (wr_req),
		.wr_idx   (cfg_idx),
		.wr_data  (pwdata[7:0]),
		.nv_ack   (nv_ack),
		.nv_rdata (nv_rdata),
		.nv_rd    (nv_rd),
		.nv_wr    (nv_wr),
		.nv_addr  (nv_addr),
		.nv_wdata (nv_wdata),
		.ld_we    (ld_we),
		.ld_idx   (ld_idx),
		.ld_data  (ld_data),
		.busy     (ld_busy),
		.done     (ld_done)
	);

	wire any_error = trk_sum[0].error || trk_sum[1].error
		|| trk_sum[2].error;

	swr_indicator #(
		.ERR_CYCLES (ERR_CYCLES)
	) u_indicator (
		.pclk           (pclk),
		.presetn        (presetn),
		.usb_configured (usb_configured),
		.usb_suspend    (usb_suspend),
		.swipe_active   (swipe_active),
		.swipe_done     (swipe_done),
		.swipe_error    (any_error),
		.led_red        (led_red),
		.led_green      (led_green)
	);

	// ----------------------------------------------------------------
	// Keystroke framer
	// ----------------------------------------------------------------
	swr_pkg::swr_trk_sum_type cur;
	assign cur = sum_reg[trk_reg];
	wire slot_free = !key_valid || key_ready;
	wire take      = trk_char_valid && trk_char_ready;
	wire [7:0] pre_card  = cfg_reg[swr_pkg::CFG_PRE_CARD];
	wire [7:0] post_card = cfg_reg[swr_pkg::CFG_POST_CARD];
	wire [7:0] pre_trk   = cfg_reg[swr_pkg::CFG_PRE_TRACK];
	wire [7:0] post_trk  = cfg_reg[swr_pkg::CFG_POST_TRACK];
	wire [7:0] term_ch   = cfg_reg[swr_pkg::CFG_TERM];

	// Start sentinel by track and detected encoding
	wire [7:0] t3_ss =
		cur.enc == swr_pkg::ENC_ISO ? cfg_reg[swr_pkg::CFG_T3_BANK] :
		cur.enc == swr_pkg::ENC_LICENCE ?
			cfg_reg[swr_pkg::CFG_T3_LICENCE] :
		cur.enc == swr_pkg::ENC_MOTOR ? cfg_reg[swr_pkg::CFG_T3_MOTOR] :
		cfg_reg[swr_pkg::CFG_T3_WIDE];
	wire [7:0] t2_ss = cur.enc == swr_pkg::ENC_WIDE ?
		cfg_reg[swr_pkg::CFG_T2_WIDE] : swr_pkg::CH_T2_SS;
	wire [7:0] ss_ch = trk_reg == 2'h0 ? swr_pkg::CH_T1_SS :
		trk_reg == 2'h1 ? t2_ss : t3_ss;

	// Sequencer: a zero wrapper character means "send nothing"
	always_comb begin
		want = 1'b0;
		gate = 1'b1;
		ch = 8'h00;
		nxt = st_reg;
		case (st_reg)
			swr_pkg::F_IDLE: begin
				gate = swipe_done && ld_done;
				nxt = full_reg ? swr_pkg::F_PRECARD : swr_pkg::F_PRETRK;
			end
			swr_pkg::F_PRECARD: begin
				want = pre_card != 8'h00;
				ch = pre_card;
				nxt = swr_pkg::F_PRETRK;
			end
			swr_pkg::F_PRETRK: begin
				want = cur.present && full_reg && pre_trk != 8'h00;
				ch = pre_trk;
				nxt = cur.present ? swr_pkg::F_SS
					: swr_pkg::F_NEXT;
			end
			swr_pkg::F_SS: begin
				want = 1'b1;
				ch = ss_ch;
				nxt = swr_pkg::F_DATA;
			end
			swr_pkg::F_DATA: begin
				nxt = swr_pkg::F_ES;
				if (cur.error) begin
					want = 1'b1;
					ch = swr_pkg::CH_ERR;
				end else begin
					gate = take && trk_char_last;
				end
			end
			swr_pkg::F_ES: begin
				want = 1'b1;
				ch = swr_pkg::CH_ES;
				nxt = full_reg ? swr_pkg::F_LRC : swr_pkg::F_NEXT;
			end
			swr_pkg::F_LRC: begin
				want = 1'b1;
				ch = cur.lrc;
				nxt = swr_pkg::F_POSTTRK;
			end
			swr_pkg::F_POSTTRK: begin
				want = post_trk != 8'h00;
				ch = post_trk;
				nxt = swr_pkg::F_TERM;
			end
			swr_pkg::F_TERM: begin
				want = term_ch != 8'h00;
				ch = term_ch;
				nxt = swr_pkg::F_NEXT;
			end
			swr_pkg::F_NEXT: begin
				nxt = trk_reg == 2'h2 ? swr_pkg::F_END : swr_pkg::F_PRETRK;
			end
			swr_pkg::F_END: begin
				want = full_reg ? post_card != 8'h00 : 1'b1;
				ch = full_reg ? post_card : swr_pkg::CH_CR;
				nxt = swr_pkg::F_IDLE;
			end
			default: nxt = swr_pkg::F_IDLE;
		endcase
		step = gate && (!want || slot_free);
		st_next = step ? nxt : st_reg;
	end

	wire emit = step && want;
	wire key_valid_next = emit || take || (key_valid && !key_ready);
	// Source ready only when the key slot is certain to be empty
	wire rdy_next = st_next == swr_pkg::F_DATA && !cur.error
		&& !key_valid_next;

	// Framer state, track walk and swipe count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= swr_pkg::F_IDLE;
			trk_reg <= 2'h0;
			sum_reg <= '0;
			swipe_cnt_reg <= 16'h0;
			trk_char_ready <= 1'b0;
		end else begin
			st_reg <= st_next;
			trk_char_ready <= rdy_next;
			if (step && st_reg == swr_pkg::F_IDLE) begin
				trk_reg <= 2'h0;
				sum_reg <= trk_sum;
				swipe_cnt_reg <= swipe_cnt_reg + 16'h1;
			end else if (step && st_reg == swr_pkg::F_NEXT
				&& trk_reg != 2'h2) begin
				trk_reg <= trk_reg + 2'h1;
			end
		end
	end

	// Key slot: held until the HID keyboard engine takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_valid <= 1'b0;
			key <= '0;
		end else begin
			key_valid <= key_valid_next;
			if (emit) key <= swr_pkg::to_key(ch);
			else if (take) key <= swr_pkg::to_key(trk_char);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ss_sent;
		st_reg == swr_pkg::F_SS && slot_free ##1 key_valid;
	endsequence

	a_upper_case_only: assert property (
		key_valid && !key.ctrl |-> !(key.code >= 7'h61
		&& key.code <= 7'h7A)) else $error("lower case key sent");
	a_ctrl_combination: assert property (
		key_valid && key.ctrl |-> (key.code >= 7'h40
		&& key.code <= 7'h5F) || key.code == 7'h3F)
		else $error("bad control key code");
	a_absent_track_silent: assert property (
		st_reg == swr_pkg::F_PRETRK && !cur.present
		|=> st_reg == swr_pkg::F_NEXT && !$rose(key_valid))
		else $error("output for empty track");
	a_error_letter_e: assert property (
		st_reg == swr_pkg::F_DATA && cur.error && slot_free
		|=> key_valid && key.code == 7'h45 && st_reg == swr_pkg::F_ES)
		else $error("failed track not marked E");
	a_loaded_before_swipe: assert property (
		st_reg != swr_pkg::F_IDLE |-> ld_done)
		else $error("swipe formatted before store load");
	a_card_end_idle: assert property (
		st_reg == swr_pkg::F_END && slot_free
		|=> st_reg == swr_pkg::F_IDLE)
		else $error("framer did not return to idle");
	a_sentinel_then_data: assert property (
		s_ss_sent |-> st_reg == swr_pkg::F_DATA && !trk_char_ready)
		else $error("sentinel not followed by data phase");
	a_store_write_stall: assert property (
		wr_req |=> !pready [*2])
		else $error("answered before store write completed");
endmodule

// *** bench/swr_nv_model.sv ***
`timescale 1ns/10ps
module swr_nv_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       nv_rd,
	input  wire logic       nv_wr,
	input  wire logic [3:0] nv_addr,
	output logic            nv_ack,
	output logic      [7:0] nv_rdata
);
	logic [2:0] wait_reg;
	// Odd places answer slowly; idle data toggles so stale reads show
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_reg <= 3'h0;
			nv_ack <= 1'b0;
			nv_rdata <= 8'h00;
		end else begin
			nv_ack <= 1'b0;
			nv_rdata <= ~nv_rdata;
			wait_reg <= 3'h0;
			if ((nv_rd || nv_wr) && !nv_ack) begin
				wait_reg <= wait_reg + 3'h1;
				if (wait_reg == (nv_addr[0] ? 3'h4 : 3'h1)) begin
					nv_ack <= 1'b1;
					nv_rdata <= swr_pkg::CFG_RESET[nv_addr];
				end
			end
		end
	end
endmodule

// *** bench/test_swipe_reader_keystroke_formatter.sv ***
`timescale 1ns/10ps
module test_swipe_reader_keystroke_formatter;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, trk_char = 8'h00, nv_rdata, nv_wdata;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, usb_configured = 0, usb_suspend = 0;
	logic swipe_active = 0, swipe_done = 0, trk_char_valid = 0;
	logic trk_char_last = 0, trk_char_ready, key_valid, key_ready = 0;
	logic led_red, led_green, nv_rd, nv_wr, nv_ack;
	logic [3:0] nv_addr;
	logic [7:0] sent [4] = '{8'h2B, 8'h21, 8'h23, 8'h26};
	swr_pkg::swr_trk_sum_type [2:0] trk_sum = '0;
	swr_pkg::swr_key_type key, keys [$];
	int miscompares = 0, checks = 0;
	swr_reader_top #(.ERR_CYCLES(20)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.usb_configured, .usb_suspend, .swipe_active, .swipe_done,
		.trk_sum, .trk_char_valid, .trk_char, .trk_char_last,
		.trk_char_ready, .key_valid, .key_ready, .key, .led_red,
		.led_green, .nv_rd, .nv_wr, .nv_addr, .nv_wdata, .nv_ack,
		.nv_rdata);
	swr_nv_model nv (.pclk, .presetn, .nv_rd, .nv_wr, .nv_addr, .nv_ack,
		.nv_rdata);
	always #4 pclk = ~pclk;
	// Slow consumer: ready toggles every cycle, so a key raised while ready is low must wait
	always @(posedge pclk) begin
		if (key_valid && key_ready) keys.push_back(key);
		key_ready <= ~key_ready;
	end
	// --------------------------------------------------
	// Bus, stream and compare helpers
	// --------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	// An idle edge follows each transfer so psel never toggles twice
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic feed(input logic [7:0] c, input logic l);
		trk_char_valid <= 1;
		trk_char <= c;
		trk_char_last <= l;
		do @(posedge pclk); while (trk_char_ready !== 1'b1);
	endtask
	// Waits for the lamp to settle green before moving a card
	task automatic swipe(input swr_pkg::swr_trk_sum_type [2:0] s);
		repeat (25) @(posedge pclk);
		swipe_active <= 1;
		repeat (4) @(posedge pclk);
		check({led_red, led_green}, 2'b00);
		swipe_active <= 0;
		swipe_done <= 1;
		trk_sum <= s;
		@(posedge pclk);
		swipe_done <= 0;
		repeat (2) @(posedge pclk);
		err = s[0].error | s[1].error | s[2].error;
		check({led_red, led_green}, {err, !err});
	endtask
	task automatic expect_keys(input logic [7:0] e [$]);
		wait (keys.size() >= e.size());
		repeat (20) @(posedge pclk);
		check(keys.size(), e.size());
		foreach (e[i]) check(keys[i], e[i]);
		keys.delete();
		$display("swipe test done");
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Whole run needs under a thousand cycles; this is ample margin
	initial begin
		#100us;
		miscompares++;
		results();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		check({led_red, led_green}, 2'b10);
		usb_configured <= 1;
		repeat (3) @(posedge pclk);
		check({led_red, led_green}, 2'b01);
		apb(0, 8'h0C, 32'h0);
		check(rd, swr_pkg::IDENT_WORD);
		apb(0, 8'h40, 32'h0);
		check(rd, 32'h0000000D);
		apb(0, 8'h20, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		swipe({24'h0, 1'b1, 1'b0, 10'h000});
		feed(8'h61, 0);
		feed(8'h0D, 0);
		feed(8'h7F, 1);
		trk_char_valid <= 0;
		expect_keys('{8'h25, 8'h41, 8'hCD, 8'hBF, 8'h3F, 8'hCD});
		for (int i = 0; i < 4; i++) begin
			swipe({1'b1, 1'b1, 2'(i), 8'h00, 24'h0});
			expect_keys('{sent[i], 8'h45, 8'h3F, 8'hCD});
		end
		// Suspend mid error display must freeze and then restore red
		swipe({24'h0, 1'b1, 1'b1, 10'h000});
		usb_suspend <= 1;
		repeat (30) @(posedge pclk);
		check({led_red, led_green}, 2'b00);
		usb_suspend <= 0;
		repeat (2) @(posedge pclk);
		check({led_red, led_green}, 2'b10);
		repeat (25) @(posedge pclk);
		check({led_red, led_green}, 2'b01);
		expect_keys('{8'h25, 8'h45, 8'h3F, 8'hCD});
		// Full format: pre-card wrapper, LRC and terminator
		apb(1, 8'h00, 32'h1);
		apb(1, 8'h44, 32'h3C);
		check({nv_addr, nv_wdata}, {4'h1, 8'h3C});
		apb(0, 8'h44, 32'h0);
		check(rd, 32'h3C);
		swipe({12'h0, 4'hF, 8'h31, 4'hC, 8'h55});
		expect_keys('{8'h3C, 8'h25, 8'h45, 8'h3F, 8'h55, 8'hCD, 8'h40,
			8'h45, 8'h3F, 8'h31, 8'hCD});
		apb(0, 8'h08, 32'h0);
		check(rd, 32'h7);
		results();
	end
endmodule
